// ---- src/lps_map.vh ----
// offsets, field positions, reset values and timing counts of the light/proximity register bank
`ifndef LPS_MAP_VH
`define LPS_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LPS_REG_RSVD 8'h00
`define LPS_REG_CONFIG 8'h01
`define LPS_REG_IRQ 8'h02
`define LPS_REG_PROX_LO 8'h03
`define LPS_REG_PROX_HI 8'h04
`define LPS_REG_LIGHT_A 8'h05
`define LPS_REG_LIGHT_B 8'h06
`define LPS_REG_LIGHT_C 8'h07
`define LPS_REG_PROX_RES 8'h08
`define LPS_REG_LIGHT_RES_LO 8'h09
`define LPS_REG_LIGHT_RES_HI 8'h0A
`define LPS_REG_FACTORY_A 8'h0E
`define LPS_REG_FACTORY_B 8'h0F

// ----------------------------------------------------------------
// measure_config fields
// ----------------------------------------------------------------
`define LPS_CFG_PROX_EN 7
`define LPS_CFG_SLEEP_HI 6
`define LPS_CFG_SLEEP_LO 4
`define LPS_CFG_LED_DRIVE 3
`define LPS_CFG_LIGHT_EN 2
`define LPS_CFG_RANGE 1
`define LPS_CFG_VIS_IR 0

// ----------------------------------------------------------------
// irq_control fields
// ----------------------------------------------------------------
`define LPS_IRQ_PROX_FLAG 7
`define LPS_IRQ_PROXIMITY_PERSISTENCE_HI 6
`define LPS_IRQ_PROXIMITY_PERSISTENCE_LO 5
`define LPS_IRQ_LIGHT_FLAG 3
`define LPS_IRQ_LIGHT_PRST_HI 2
`define LPS_IRQ_LIGHT_PRST_LO 1
`define LPS_IRQ_COMBINE 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LPS_RST_CONFIG 8'h00
`define LPS_RST_PROX_LO 8'h00
`define LPS_RST_PROX_HI 8'hFF
`define LPS_RST_LIGHT_A 8'h00
`define LPS_RST_LIGHT_B 8'hF0
`define LPS_RST_LIGHT_C 8'hFF
`define LPS_RST_RESULT 8'h00
`define LPS_RST_FACTORY 8'h00

// ----------------------------------------------------------------
// persistence counts and bus address (address value is arbitrary)
// ----------------------------------------------------------------
`define LPS_PRST_CNT0 5'h01
`define LPS_PRST_CNT1 5'h04
`define LPS_PRST_CNT2 5'h08
`define LPS_PRST_CNT3 5'h10
`define LPS_DEV_ADDR 7'h2A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// sleep gaps in cycles of the 50 MHz clock, sized to the 26-bit sleep counter
`define LPS_SLP_12P5_CYC 26'h0098968
`define LPS_SLP_50_CYC 26'h02625A0
`define LPS_SLP_75_CYC 26'h0393870
`define LPS_SLP_100_CYC 26'h04C4B40
`define LPS_SLP_200_CYC 26'h0989680
`define LPS_SLP_400_CYC 26'h1312D00
`define LPS_SLP_800_CYC 26'h2625A00

`endif

// ---- src/lps_persist.v ----
// persistence counter and sticky event flag for one measurement channel
`timescale 1ns/1ns
`default_nettype none
`include "lps_map.vh"

module lps_persist
(
  input wire clk, // system clock
  input wire rst, // synchronous reset, high
  input wire ce, // clock enable
  input wire done, // one conversion finished
  input wire trip, // that conversion tripped the thresholds
  input wire [1:0] persist_sel, // persistence code
  input wire clear, // host wrote zero to the flag
  output reg flag // sticky event flag
);

  reg [4:0] run_len;
  reg [4:0] next_run_len;
  reg [4:0] needed;

  always @*
  begin
    case (persist_sel)
      2'h0: needed = `LPS_PRST_CNT0;
      2'h1: needed = `LPS_PRST_CNT1;
      2'h2: needed = `LPS_PRST_CNT2;
      default: needed = `LPS_PRST_CNT3;
    endcase
    // saturate so a long run never wraps back below the target
    if (!trip)
      next_run_len = 5'h00;
    else if (run_len == `LPS_PRST_CNT3)
      next_run_len = run_len;
    else
      next_run_len = run_len + 5'h01;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      run_len <= 5'h00;
      flag <= 1'b0;
    end
    else if (ce)
    begin
      if (done)
        run_len <= next_run_len;
      // a new event in the clearing cycle wins over the clear
      if (done && trip && next_run_len >= needed)
        flag <= 1'b1;
      else if (clear)
        flag <= 1'b0;
    end
  end

endmodule // lps_persist
`default_nettype wire

// ---- src/lps_prox_pacer.v ----
// paces proximity conversions: LED pulse window, then the selected sleep time
`timescale 1ns/1ns
`default_nettype none
`include "lps_map.vh"

module lps_prox_pacer
#(
  parameter [25:0] SLP_12P5_CYC = `LPS_SLP_12P5_CYC, // 12.5 ms
  parameter [25:0] SLP_50_CYC = `LPS_SLP_50_CYC, // 50 ms
  parameter [25:0] SLP_75_CYC = `LPS_SLP_75_CYC, // 75 ms
  parameter [25:0] SLP_100_CYC = `LPS_SLP_100_CYC, // 100 ms
  parameter [25:0] SLP_200_CYC = `LPS_SLP_200_CYC, // 200 ms
  parameter [25:0] SLP_400_CYC = `LPS_SLP_400_CYC, // 400 ms
  parameter [25:0] SLP_800_CYC = `LPS_SLP_800_CYC // 800 ms
)
(
  input wire clk, // system clock
  input wire rst, // synchronous reset, high
  input wire ce, // clock enable
  input wire enable, // proximity sensing on
  input wire [2:0] sleep_sel, // proximity_sleep_sel
  input wire done, // proximity conversion finished
  output reg start, // one-cycle conversion request
  output reg led_on // LED sink active during the conversion
);

  localparam [1:0] P_IDLE = 2'h0;
  localparam [1:0] P_PULSE = 2'h1;
  localparam [1:0] P_SLEEP = 2'h2;

  reg [1:0] state;
  reg [25:0] count;
  reg [25:0] sleep_len;

  always @*
  begin
    case (sleep_sel)
      3'h7: sleep_len = 26'h0000000;
      3'h6: sleep_len = SLP_12P5_CYC;
      3'h5: sleep_len = SLP_50_CYC;
      3'h4: sleep_len = SLP_75_CYC;
      3'h3: sleep_len = SLP_100_CYC;
      3'h2: sleep_len = SLP_200_CYC;
      3'h1: sleep_len = SLP_400_CYC;
      default: sleep_len = SLP_800_CYC;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state <= P_IDLE;
      count <= 26'h0000000;
      start <= 1'b0;
      led_on <= 1'b0;
    end
    else if (ce)
    begin
      start <= 1'b0;
      case (state)
        P_IDLE:
          if (enable)
          begin
            start <= 1'b1;
            led_on <= 1'b1;
            state <= P_PULSE;
          end
        P_PULSE:
          if (!enable)
          begin
            led_on <= 1'b0;
            state <= P_IDLE;
          end
          else if (done)
          begin
            if (sleep_len == 26'h0000000)
            begin
              start <= 1'b1; // continuous running, no idle gap
            end
            else
            begin
              led_on <= 1'b0;
              count <= sleep_len;
              state <= P_SLEEP;
            end
          end
        P_SLEEP:
          if (!enable)
            state <= P_IDLE;
          else if (count == 26'h0000001)
          begin
            start <= 1'b1;
            led_on <= 1'b1;
            state <= P_PULSE;
          end
          else
            count <= count - 26'h0000001;
        default:
          state <= P_IDLE;
      endcase
    end
  end

endmodule // lps_prox_pacer
`default_nettype wire

// ---- src/lps_regmap.v ----
// light/proximity register bank behind a two-wire serial slave, with interrupt pin
`timescale 1ns/1ns
`default_nettype none
`include "lps_map.vh"


module lps_regmap
#(
  parameter [6:0] DEV_ADDR = `LPS_DEV_ADDR, // bus address, value arbitrary
  parameter [25:0] SLP_12P5_CYC = `LPS_SLP_12P5_CYC, // 12.5 ms in cycles
  parameter [25:0] SLP_50_CYC = `LPS_SLP_50_CYC, // 50 ms in cycles
  parameter [25:0] SLP_75_CYC = `LPS_SLP_75_CYC, // 75 ms in cycles
  parameter [25:0] SLP_100_CYC = `LPS_SLP_100_CYC, // 100 ms in cycles
  parameter [25:0] SLP_200_CYC = `LPS_SLP_200_CYC, // 200 ms in cycles
  parameter [25:0] SLP_400_CYC = `LPS_SLP_400_CYC, // 400 ms in cycles
  parameter [25:0] SLP_800_CYC = `LPS_SLP_800_CYC // 800 ms in cycles
)
(
  input wire CLK, // 50 MHz clock
  input wire RESET, // synchronous reset, high
  input wire CE, // clock enable, low freezes all state
  input wire SCL, // serial clock pin
  input wire SDA_IN, // serial data pin level
  output reg SDA_OUT, // serial data output level, always low
  output reg SDA_OE, // high while pulling serial data low
  output reg INT_N, // interrupt pin, low active
  input wire [7:0] PROX_VALUE, // proximity conversion value
  input wire PROX_DONE, // proximity conversion finished
  input wire [11:0] LIGHT_VALUE, // light conversion value
  input wire LIGHT_DONE, // light conversion finished
  output wire PROX_ENABLE, // proximity sensing on
  output wire [2:0] PROXIMITY_SLEEP_SEL, // sleep code
  output wire LED_DRIVE_SEL, // high LED current
  output wire LIGHT_SENSE_ENABLE, // light sensing on
  output wire LIGHT_RANGE_SEL, // high-lux range
  output wire VISIBLE_OR_INFRARED_SEL, // infrared data selected
  output wire PROX_START, // proximity conversion request pulse
  output wire LED_SINK_PIN // LED sink active
);

  // ----------------------------------------------------------------
  // serial state codes
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_ADDR_ACK = 4'h2;
  localparam [3:0] S_REG = 4'h3;
  localparam [3:0] S_REG_ACK = 4'h4;
  localparam [3:0] S_WDATA = 4'h5;
  localparam [3:0] S_WDATA_ACK = 4'h6;
  localparam [3:0] S_RDATA = 4'h7;
  localparam [3:0] S_RDATA_ACK = 4'h8;

  reg scl_meta;
  reg scl_sync;
  reg scl_prev;
  reg sda_meta;
  reg sda_sync;
  reg sda_prev;
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg rw;
  reg [7:0] cfg;
  reg [1:0] proximity_persistence;
  reg [1:0] light_prst;
  reg combine;
  reg [7:0] prox_lo;
  reg [7:0] prox_hi;
  reg [7:0] light_a;
  reg [7:0] light_b;
  reg [7:0] light_c;
  reg [7:0] prox_res;
  reg [11:0] light_res;
  reg [7:0] factory_a;
  reg [7:0] factory_b;
  reg [7:0] rd_data;
  wire prox_flag;
  wire light_flag;

  function outside_window;
    input [11:0] value;
    input [11:0] low;
    input [11:0] high;
    begin
      outside_window = (value < low) || (value > high);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin sampling and bus conditions
  // ----------------------------------------------------------------
  // both lines idle high, so the sampling chain resets high to avoid a false start
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else if (CE)
    begin
      scl_meta <= SCL;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= SDA_IN;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  wire scl_rise = scl_sync & ~scl_prev;
  wire scl_fall = ~scl_sync & scl_prev;
  wire start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  wire stop_cond = scl_sync & scl_prev & ~sda_prev & sda_sync;
  wire host_wr = scl_fall && (state == S_WDATA) && (bit_cnt == 4'h8);
  wire irq_wr = host_wr && (ptr == `LPS_REG_IRQ);

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always @*
  begin
    case (ptr)
      `LPS_REG_CONFIG: rd_data = cfg;
      `LPS_REG_IRQ: rd_data = {prox_flag, proximity_persistence, 1'b0, light_flag, light_prst, combine};
      `LPS_REG_PROX_LO: rd_data = prox_lo;
      `LPS_REG_PROX_HI: rd_data = prox_hi;
      `LPS_REG_LIGHT_A: rd_data = light_a;
      `LPS_REG_LIGHT_B: rd_data = light_b;
      `LPS_REG_LIGHT_C: rd_data = light_c;
      `LPS_REG_PROX_RES: rd_data = prox_res;
      `LPS_REG_LIGHT_RES_LO: rd_data = light_res[7:0];
      `LPS_REG_LIGHT_RES_HI: rd_data = {4'h0, light_res[11:8]};
      `LPS_REG_FACTORY_A: rd_data = factory_a;
      `LPS_REG_FACTORY_B: rd_data = factory_b;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  // data changes only after a seen falling edge, so own drive never mimics start or stop
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      SDA_OE <= 1'b0;
      SDA_OUT <= 1'b0;
    end
    else if (CE)
    begin
      SDA_OUT <= 1'b0;
      if (start_cond)
      begin
        state <= S_ADDR;
        bit_cnt <= 4'h0;
        SDA_OE <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= S_IDLE;
        SDA_OE <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state)
          S_ADDR, S_REG, S_WDATA:
          begin
            shreg <= {shreg[6:0], sda_sync};
            bit_cnt <= bit_cnt + 4'h1;
          end
          S_RDATA:
            bit_cnt <= bit_cnt + 4'h1;
          S_RDATA_ACK:
            if (sda_sync)
              state <= S_IDLE;
            else
              ptr <= ptr + 8'h01;
          default:
            state <= state;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          S_ADDR:
            if (bit_cnt == 4'h8)
            begin
              if (shreg[7:1] == DEV_ADDR)
              begin
                rw <= shreg[0];
                SDA_OE <= 1'b1;
                state <= S_ADDR_ACK;
              end
              else
                state <= S_IDLE;
            end
          S_ADDR_ACK:
          begin
            bit_cnt <= 4'h0;
            if (rw)
            begin
              shreg <= rd_data;
              SDA_OE <= ~rd_data[7];
              state <= S_RDATA;
            end
            else
            begin
              SDA_OE <= 1'b0;
              state <= S_REG;
            end
          end
          S_REG:
            if (bit_cnt == 4'h8)
            begin
              ptr <= shreg;
              SDA_OE <= 1'b1;
              state <= S_REG_ACK;
            end
          S_REG_ACK:
          begin
            SDA_OE <= 1'b0;
            bit_cnt <= 4'h0;
            state <= S_WDATA;
          end
          S_WDATA:
            if (bit_cnt == 4'h8)
            begin
              SDA_OE <= 1'b1;
              state <= S_WDATA_ACK;
            end
          S_WDATA_ACK:
          begin
            SDA_OE <= 1'b0;
            ptr <= ptr + 8'h01;
            bit_cnt <= 4'h0;
            state <= S_WDATA;
          end
          S_RDATA:
            if (bit_cnt == 4'h8)
            begin
              SDA_OE <= 1'b0;
              state <= S_RDATA_ACK;
            end
            else
            begin
              shreg <= {shreg[6:0], 1'b0};
              SDA_OE <= ~shreg[6];
            end
          S_RDATA_ACK:
          begin
            shreg <= rd_data;
            SDA_OE <= ~rd_data[7];
            bit_cnt <= 4'h0;
            state <= S_RDATA;
          end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  wire prox_take = PROX_DONE & cfg[`LPS_CFG_PROX_EN];
  wire light_take = LIGHT_DONE & cfg[`LPS_CFG_LIGHT_EN];
  wire prox_trip = outside_window({4'h0, PROX_VALUE}, {4'h0, prox_lo}, {4'h0, prox_hi});
  wire light_trip = outside_window(LIGHT_VALUE, {light_b[3:0], light_a},
    {light_c, light_b[7:4]});

  always @(posedge CLK)
  begin
    if (RESET)
    begin
      cfg <= `LPS_RST_CONFIG;
      proximity_persistence <= 2'h0;
      light_prst <= 2'h0;
      combine <= 1'b0;
      prox_lo <= `LPS_RST_PROX_LO;
      prox_hi <= `LPS_RST_PROX_HI;
      light_a <= `LPS_RST_LIGHT_A;
      light_b <= `LPS_RST_LIGHT_B;
      light_c <= `LPS_RST_LIGHT_C;
      prox_res <= `LPS_RST_RESULT;
      light_res <= 12'h000;
      factory_a <= `LPS_RST_FACTORY;
      factory_b <= `LPS_RST_FACTORY;
      INT_N <= 1'b1;
    end
    else if (CE)
    begin
      if (host_wr)
      begin
        case (ptr)
          `LPS_REG_CONFIG: cfg <= shreg;
          `LPS_REG_IRQ:
          begin
            proximity_persistence <= shreg[`LPS_IRQ_PROXIMITY_PERSISTENCE_HI:`LPS_IRQ_PROXIMITY_PERSISTENCE_LO];
            light_prst <= shreg[`LPS_IRQ_LIGHT_PRST_HI:`LPS_IRQ_LIGHT_PRST_LO];
            combine <= shreg[`LPS_IRQ_COMBINE];
          end
          `LPS_REG_PROX_LO: prox_lo <= shreg;
          `LPS_REG_PROX_HI: prox_hi <= shreg;
          `LPS_REG_LIGHT_A: light_a <= shreg;
          `LPS_REG_LIGHT_B: light_b <= shreg;
          `LPS_REG_LIGHT_C: light_c <= shreg;
          `LPS_REG_FACTORY_A: factory_a <= shreg;
          `LPS_REG_FACTORY_B: factory_b <= shreg;
          default: cfg <= cfg;
        endcase
      end
      if (prox_take)
        prox_res <= PROX_VALUE;
      if (light_take)
        light_res <= LIGHT_VALUE;
      INT_N <= ~(combine ? (prox_flag & light_flag) : (prox_flag | light_flag));
    end
  end

  // ----------------------------------------------------------------
  // event flags and proximity pacing
  // ----------------------------------------------------------------
  lps_persist u_prox_persist
  (
    .clk(CLK),
    .rst(RESET),
    .ce(CE),
    .done(prox_take),
    .trip(prox_trip),
    .persist_sel(proximity_persistence),
    .clear(irq_wr & ~shreg[`LPS_IRQ_PROX_FLAG]),
    .flag(prox_flag)
  );

  lps_persist u_light_persist
  (
    .clk(CLK),
    .rst(RESET),
    .ce(CE),
    .done(light_take),
    .trip(light_trip),
    .persist_sel(light_prst),
    .clear(irq_wr & ~shreg[`LPS_IRQ_LIGHT_FLAG]),
    .flag(light_flag)
  );

  lps_prox_pacer
  #(
    .SLP_12P5_CYC(SLP_12P5_CYC),
    .SLP_50_CYC(SLP_50_CYC),
    .SLP_75_CYC(SLP_75_CYC),
    .SLP_100_CYC(SLP_100_CYC),
    .SLP_200_CYC(SLP_200_CYC),
    .SLP_400_CYC(SLP_400_CYC),
    .SLP_800_CYC(SLP_800_CYC)
  )
  u_pacer
  (
    .clk(CLK),
    .rst(RESET),
    .ce(CE),
    .enable(cfg[`LPS_CFG_PROX_EN]),
    .sleep_sel(cfg[`LPS_CFG_SLEEP_HI:`LPS_CFG_SLEEP_LO]),
    .done(PROX_DONE),
    .start(PROX_START),
    .led_on(LED_SINK_PIN)
  );

  assign PROX_ENABLE = cfg[`LPS_CFG_PROX_EN];
  assign PROXIMITY_SLEEP_SEL = cfg[`LPS_CFG_SLEEP_HI:`LPS_CFG_SLEEP_LO];
  assign LED_DRIVE_SEL = cfg[`LPS_CFG_LED_DRIVE];
  assign LIGHT_SENSE_ENABLE = cfg[`LPS_CFG_LIGHT_EN];
  assign LIGHT_RANGE_SEL = cfg[`LPS_CFG_RANGE];
  assign VISIBLE_OR_INFRARED_SEL = cfg[`LPS_CFG_VIS_IR];

endmodule // lps_regmap
`default_nettype wire

// ---- tb/lps_regmap_asserts.sv ----
// pin-level assertions for the light/proximity register bank
`timescale 1ns/1ns
`default_nettype none
module lps_regmap_asserts (
  input wire logic CLK, // clock
  input wire logic RESET, // reset
  input wire logic SCL, // bus clock
  input wire logic SDA_OUT, // data level
  input wire logic SDA_OE, // data pull
  input wire logic INT_N, // irq pin
  input wire logic PROX_DONE, // prox done
  input wire logic LIGHT_DONE, // light done
  input wire logic PROX_ENABLE, // prox on
  input wire logic [2:0] PROXIMITY_SLEEP_SEL, // sleep code
  input wire logic PROX_START, // prox start
  input wire logic LED_SINK_PIN // led on
);
  wire logic any_done = PROX_DONE | LIGHT_DONE;
  // a done pulse only ends a conversion while the pacer has the led on
  wire logic busy_done = PROX_DONE & LED_SINK_PIN & PROX_ENABLE;
  wire logic no_sleep = PROXIMITY_SLEEP_SEL == 3'h7;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_data_low: assert property (SDA_OUT == 1'b0)
    else $error("data driven high");
  chk_reset_idle: assert property (disable iff (1'b0) RESET |=> INT_N && !SDA_OE)
    else $error("pins not idle after reset");
  chk_start_pulse: assert property (PROX_START |=> !PROX_START)
    else $error("start longer than a cycle");
  chk_start_led: assert property (PROX_START |-> LED_SINK_PIN)
    else $error("start without led");
  chk_enable_start: assert property ($rose(PROX_ENABLE) |-> ##[0:2] PROX_START)
    else $error("enable gave no start");
  chk_no_sleep: assert property (busy_done && no_sleep |-> ##[1:2] PROX_START)
    else $error("no restart without sleep");
  chk_sleep_gap: assert property (busy_done && !no_sleep |=> !PROX_START [*8])
    else $error("restart inside sleep");
  chk_int_cause: assert property ($fell(INT_N) |-> $past(any_done, 2) || $past(any_done, 3))
    else $error("irq pin fell without event");
  chk_ack_scl_low: assert property ($rose(SDA_OE) |-> !$past(SCL, 2))
    else $error("data pulled outside clock low");
endmodule // lps_regmap_asserts
bind lps_regmap lps_regmap_asserts lps_regmap_asserts_inst (.*);
`default_nettype wire

// ---- tb/lps_host_model.sv ----
// serial bus controller model for the register bank
`timescale 1ns/1ns
`default_nettype none
module lps_host_model (
  input wire logic sda_oe, // device pulls data
  output logic scl, // bus clock, still between frames
  output wire logic sda // data line level
);
  logic pull;
  assign sda = !(pull || sda_oe);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start_cond;
    #20 pull = 1'b0;
    #60 scl = 1'b1;
    #40 pull = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop_cond;
    #20 pull = 1'b1;
    #60 scl = 1'b1;
    #40 pull = 1'b0;
    #80;
  endtask
  // eight bits then the acknowledge slot, msb first
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      #20 pull = !d[i];
      #60 scl = 1'b1;
      #40 q[i] = sda;
      #40 scl = 1'b0;
    end
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
    output logic ok);
    logic [8:0] a, b, c;
    start_cond;
    xfer({dev, 2'b01}, a);
    xfer({p, 1'b1}, b);
    xfer({d, 1'b1}, c);
    stop_cond;
    ok = !(a[0] | b[0] | c[0]);
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d);
    logic [8:0] q;
    start_cond;
    xfer({dev, 2'b01}, q);
    xfer({p, 1'b1}, q);
    start_cond;
    xfer({dev, 2'b11}, q);
    xfer(9'h1FF, q);
    stop_cond;
    d = q[8:1];
  endtask
endmodule // lps_host_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the light/proximity register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [6:0] DA = 7'h2A; // bus address, value arbitrary
  logic CLK, RESET, CE, SCL, SDA_IN, SDA_OUT, SDA_OE, INT_N, PROX_DONE, LIGHT_DONE;
  logic PROX_ENABLE, LED_DRIVE_SEL, LIGHT_SENSE_ENABLE, LIGHT_RANGE_SEL;
  logic VISIBLE_OR_INFRARED_SEL, PROX_START, LED_SINK_PIN;
  logic [2:0] PROXIMITY_SLEEP_SEL;
  logic [7:0] PROX_VALUE, seen;
  logic [11:0] LIGHT_VALUE;
  logic [7:0] exp_q[$];
  logic [7:0] rst_val[16] = '{0, 0, 0, 0, 8'hFF, 0, 8'hF0, 8'hFF, 0, 0, 0, 0, 0, 0, 0, 0};
  int cnt[4] = '{1, 4, 8, 16};
  int n_errors = 0;
  int total_checks = 0;
  string what;
  event got;
  wire logic [7:0] cfg_pins = {PROX_ENABLE, PROXIMITY_SLEEP_SEL, LED_DRIVE_SEL,
    LIGHT_SENSE_ENABLE, LIGHT_RANGE_SEL, VISIBLE_OR_INFRARED_SEL};
  // short sleep counts keep the pacer inside the run; 200/400 ms codes keep their full counts and never wake here
  lps_regmap #(.SLP_12P5_CYC(20), .SLP_50_CYC(40), .SLP_75_CYC(60), .SLP_100_CYC(80),
    .SLP_800_CYC(140)) lps_regmap_inst (.*);
  lps_host_model lps_host_model_inst (.sda_oe(SDA_OE), .scl(SCL), .sda(SDA_IN));
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = !CLK;
  end
  always @(got)
  begin
    total_checks++;
    if (seen !== exp_q[0])
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp_q[0], seen);
    end
    void'(exp_q.pop_front());
  end
  task automatic publish(input string n, input logic [7:0] s);
    what = n;
    seen = s;
    -> got;
    @(posedge CLK);
    #1;
  endtask
  task automatic check_reg(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    exp_q.push_back(e);
    lps_host_model_inst.read_reg(DA, p, d);
    publish("register", d);
  endtask
  task automatic check_pin(input string n, input logic [7:0] e, input logic [7:0] s);
    exp_q.push_back(e);
    publish(n, s);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    lps_host_model_inst.write_reg(DA, p, d, ok);
  endtask
  task automatic conv(input logic px, input logic [11:0] v);
    @(posedge CLK);
    #1;
    PROX_VALUE = v[7:0];
    LIGHT_VALUE = v;
    PROX_DONE = px;
    LIGHT_DONE = !px;
    @(posedge CLK);
    #1;
    PROX_DONE = 1'b0;
    LIGHT_DONE = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_errors++;
    final_report;
  end
  initial
  begin
    logic [7:0] r;
    logic ok;
    void'($urandom(32'h303A327A));
    RESET = 1'b1;
    CE = 1'b1;
    PROX_DONE = 1'b0;
    LIGHT_DONE = 1'b0;
    PROX_VALUE = 8'h00;
    LIGHT_VALUE = 12'h000;
    repeat (16) @(posedge CLK);
    #1 RESET = 1'b0;
    for (int p = 0; p < 16; p++)
      check_reg(8'(p), rst_val[p]);
    for (int p = 3; p <= 7; p++)
    begin
      r = 8'($urandom);
      wr(8'(p), r);
      check_reg(8'(p), r);
    end
    wr(8'h08, 8'h5A);
    check_reg(8'h08, 8'h00);
    wr(8'h0C, 8'h5A);
    check_reg(8'h0C, 8'h00);
    lps_host_model_inst.write_reg(DA ^ 7'h01, 8'h03, 8'h11, ok);
    check_pin("address ack", 8'h00, {7'h00, ok});
    r = 8'($urandom);
    wr(8'h01, r);
    check_reg(8'h01, r);
    check_pin("config pins", r, cfg_pins);
    wr(8'h02, 8'hEF);
    check_reg(8'h02, 8'h67);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h20);
    wr(8'h01, 8'h04);
    conv(1'b0, 12'h3AB);
    check_reg(8'h09, 8'hAB);
    check_reg(8'h0A, 8'h03);
    for (int c = 0; c < 4; c++)
    begin
      // an in-window result first, so the run restarts from zero
      wr(8'h02, 8'(c << 1));
      conv(1'b0, 12'h150);
      repeat (cnt[c] - 1) conv(1'b0, 12'h201 + 12'($urandom_range(0, 3582)));
      check_pin("irq before count", 8'h01, {7'h00, INT_N});
      conv(1'b0, 12'h0FF);
      check_pin("irq at count", 8'h00, {7'h00, INT_N});
    end
    check_reg(8'h02, 8'h0E);
    wr(8'h02, 8'h01);
    conv(1'b0, 12'h0FF);
    check_pin("irq one flag", 8'h01, {7'h00, INT_N});
    // a done pulse while the clock enable is low must leave the result untouched
    CE = 1'b0;
    conv(1'b0, 12'h777);
    CE = 1'b1;
    check_reg(8'h09, 8'hFF);
    wr(8'h03, 8'h10);
    wr(8'h04, 8'h20);
    wr(8'h01, 8'h84);
    conv(1'b1, 12'h030);
    check_pin("irq both flags", 8'h00, {7'h00, INT_N});
    check_reg(8'h08, 8'h30);
    check_reg(8'h02, 8'h89);
    wr(8'h02, 8'h01);
    check_pin("irq cleared", 8'h01, {7'h00, INT_N});
    wr(8'h01, 8'hF0);
    conv(1'b1, 12'h015);
    final_report;
  end
endmodule // testbench
`default_nettype wire
